// ---- bench/decoder_model.sv ----
`timescale 1ns/1ps
// Decoder stand-in: presents one operation a cycle after each request, garbage otherwise.
module decoder_model (
  input  wire logic                           clk,            // System clock.
  input  wire logic                           req,            // Present an operation.
  input  wire logic [2:0]                     kindIn,         // Operation code.
  input  wire logic [12:0]                    addrIn,         // Jump or call target.
  output logic                                step = 1'b0,    // Boundary strobe.
  output program_sequencer_pkg::seq_op_s      op = '0         // Operation presented.
);
  // whole operation presented in one boundary.
  always_ff @(posedge clk) begin
    step <= req;
    op   <= req ? {kindIn, addrIn, 8'h20} : ~op;
  end
endmodule : decoder_model

// ---- bench/program_sequencer_monitor.sv ----
`timescale 1ns/1ps
// Watches the sequencer and bus ports.
module program_sequencer_monitor (
  input wire logic                        clk,            // System clock.
  input wire logic                        rst_n,          // Reset, active low.
  input wire logic                        ce,             // Clock enable.
  input wire logic                        hsel,           // Slave select.
  input wire logic [1:0]                  htrans,         // Transfer type.
  input wire logic                        hready,         // Bus ready.
  input wire logic                        hreadyout,      // Slave ready.
  input wire logic                        hresp,          // Response.
  input wire logic                        step,           // Boundary strobe.
  input wire program_sequencer_pkg::seq_op_s op,          // Operation.
  input wire logic                        ispMode,        // Programming mode.
  input wire logic [12:0]                 pc,             // Program counter.
  input wire logic                        discardFetch,   // Drop fetched word.
  input wire logic                        intTaken,       // Interrupt taken.
  input wire logic                        lookupBusy,     // Table read in progress.
  input wire logic                        portABitZeroOut, // Serial data out.
  input wire logic                        portABitZeroOe  // Serial data enable.
);
  // A step the sequencer accepts at this edge.
  wire       take = step && ce && !ispMode && !lookupBusy;
  wire [2:0] k    = op.kind;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_reset_clear: assert property ($rose(rst_n) |-> pc == 13'h0000 ##1 pc == 13'h0000)
    else $error("pc not zero after reset");
  a_jump_full: assert property (take && k == 3'd2 |=> intTaken || pc == $past(op.target))
    else $error("jump target not loaded");
  a_skip_two: assert property (take && k == 3'd1 |=> intTaken || pc == $past(pc) + 13'd2)
    else $error("skip did not advance by two");
  a_skip_discard: assert property (take && k inside {3'd1, 3'd2, 3'd3} |=> discardFetch)
    else $error("fetched word not dropped");
  a_vector_load: assert property (intTaken |-> pc inside {13'h0004, 13'h0008, 13'h000c})
    else $error("interrupt vector wrong");
  a_lookup_two: assert property (take && k[2:1] == 2'b11 |=>
    intTaken or (lookupBusy ##1 !lookupBusy)) else $error("table read not two cycles");
  a_pin_quiet: assert property (!portABitZeroOe && !portABitZeroOut)
    else $error("serial data pin driven");
  a_bus_wait: assert property (hsel && hready && htrans[1] && hreadyout |=>
    !hreadyout ##1 hreadyout) else $error("bus wait state wrong");
  a_bus_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  cover property (intTaken);
  cover property (lookupBusy);
  cover property (take && k == 3'd5);
endmodule : program_sequencer_monitor
bind program_sequencer program_sequencer_monitor mon (.clk(clk), .rst_n(rst_n), .ce(ce),
  .hsel(hsel), .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .step(step), .op(op), .ispMode(ispMode), .pc(pc), .discardFetch(discardFetch),
  .intTaken(intTaken), .lookupBusy(lookupBusy), .portABitZeroOut(portABitZeroOut),
  .portABitZeroOe(portABitZeroOe));

// ---- bench/test_program_sequencer.sv ----
`timescale 1ns/1ps
module test_program_sequencer;
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, req = 0, extInt_n = 1, t0 = 0, t1 = 0;
  logic rdWait = 0, pend = 0, hreadyout, hresp, step, intTaken;
  logic [31:0] haddr = 0, hwdata = 0, lfsr = 32'hf12b, d, hrdata, rdQ[$];
  logic [12:0] target = 0, p = 0, pc, pcQ[$], stk[$];
  logic [2:0]  kind = 0;
  logic [1:0]  htrans = 0;
  int          fail_count = 0, n_tests = 0;
  program_sequencer_pkg::seq_op_s op;
  // Clock of 100 ns period.
  always #50 clk = ~clk;
  decoder_model dec (.clk(clk), .req(req), .kindIn(kind), .addrIn(target), .step(step), .op(op));
  program_sequencer DUT (.clk(clk), .rst_n(rst_n), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .step(step), .op(op),
    .extInt_n(extInt_n), .timer0Overflow(t0), .timer1Overflow(t1), .pc(pc), .fetchWord(),
    .discardFetch(), .intTaken(intTaken), .lookupBusy(), .ispMode(1'b0), .portABitFour(1'b0),
    .portABitZeroIn(1'b1), .portABitZeroOut(), .portABitZeroOe());
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // One single word transfer; a read notes its expected data.
  task automatic bus(logic wr, logic [7:0] idx, logic [31:0] v);
    @(posedge clk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, wr, 22'h0, idx, 2'b00};
    do @(posedge clk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata, rdWait} <= {1'b0, 2'b00, v, !wr};
    if (!wr) rdQ.push_back(v);
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdWait <= 1'b0;
  endtask : bus
  // One boundary: code 0 next, 1 skip, 2 jump, 3 call, 4 return, 5 interrupt return, 6/7 table.
  task automatic run(logic [2:0] k, logic [12:0] t, logic [12:0] e);
    @(posedge clk);
    {req, kind, target} <= {1'b1, k, t};
    pcQ.push_back(e);
    p = e;
    @(posedge clk);
    req <= 1'b0;
  endtask : run
  task automatic ret(logic [2:0] k);
    run(k, 13'h0, stk.pop_back());
  endtask : ret
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  // Compares each result against the oldest note when it appears.
  always @(posedge clk) begin
    if (rdWait && hreadyout) check("hrdata", hrdata, rdQ.pop_front());
    if (pend) check("pc", {19'h0, pc}, {19'h0, pcQ.pop_front()});
    pend = step;
  end
  initial begin
    #(3000 * 100);
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    check("pc", {19'h0, pc}, 32'h0);
    d = rnd() & 32'hff;
    bus(1, 8'h08, 32'hff); bus(0, 8'h08, 32'h0);
    bus(1, 8'h07, d); bus(0, 8'h07, d);
    bus(1, 8'h20, ~d & 32'hff); bus(0, 8'h20, ~d & 32'hff);
    bus(1, 8'h01, 32'hff); bus(1, 8'h00, d); bus(0, 8'hff, d);
    bus(0, 8'h09, 32'h0);
    $display("register test done");
    d = rnd();
    run(2, d[12:0], d[12:0]);
    run(1, 13'h0, p + 13'd2);
    run(0, 13'h0, p + 13'd1);
    bus(1, 8'h06, d & 32'hff);
    run(0, 13'h0, {p[12:8], d[7:0]});
    run(6, 13'h0, p + 13'd1);
    run(7, 13'h0, p + 13'd1);
    $display("flow test done");
    bus(1, 8'h0b, 32'h07);
    for (int i = 0; i < 17; i++) begin
      d = rnd();
      stk.push_back(p + 13'd1);
      if (stk.size() > 16) void'(stk.pop_front());
      run(3, d[12:0], d[12:0]);
    end
    @(posedge clk) t1 <= 1'b1;
    @(posedge clk) t1 <= 1'b0;
    run(0, 13'h0, p + 13'd1);
    ret(4);
    stk.push_back(p);
    run(0, 13'h0, 13'h000c);
    while (stk.size() > 0) ret(5);
    @(posedge clk) {extInt_n, t0} <= 2'b01;
    @(posedge clk) t0 <= 1'b0;
    repeat (5) @(posedge clk);
    stk.push_back(p);
    run(0, 13'h0, 13'h0004);
    stk.push_back(p);
    run(5, 13'h0, 13'h0008);
    extInt_n <= 1'b1;
    ret(5); ret(5);
    repeat (3) @(posedge clk);
    $display("stack test done");
    wrap_up();
  end
endmodule : test_program_sequencer

// ---- src/program_sequencer.sv ----
// Function
// - Reset clears program counter to zero.
// - External interrupt loads vector four.
// - First counter overflow loads vector eight.
// - Second counter overflow loads vector twelve.
// - Taken skip advances counter by two.
// - Low byte write keeps page bits.
// - Jump and call load full address.
// - Return loads counter from stack top.
// - Program memory 8192 words, two addressers.
// - Current page read uses page bits.
// - Last page read forces page ones.
// - Table high byte is read only.
// - Table pointer readable and writable register.
// - Table read takes two cycles.
// - Sixteen level stack, hidden from software.
// - Call or interrupt pushes, return pops.
// - Reset empties stack, pointer at top.
// - Full stack defers interrupt acknowledge.
// - Call on full stack drops oldest.
// - 256 byte space, storage from 20h.
// - Indirect locations, pointers, bank pointer placed.
// - Serial programming on two port pins.
// - Each fetch advances counter by one.
// - Taken transfer discards fetched word.
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "program_sequencer_defines.svh"

module program_sequencer #(
  parameter int STACK_LEVELS = `STACK_LEVELS, // Return stack depth.
  parameter int PROG_WORDS   = `PROG_WORDS    // Program memory words.
) (
  input  wire logic                     clk,              // System clock, 10 MHz.
  input  wire logic                     rst_n,            // Asynchronous reset, active low.
  input  wire logic                     ce,               // Clock enable; low freezes state.
  input  wire logic                     hsel,             // AHB slave select.
  input  wire logic [31:0]              haddr,            // AHB address.
  input  wire logic [1:0]               htrans,           // AHB transfer type.
  input  wire logic                     hwrite,           // AHB write.
  input  wire logic [2:0]               hsize,            // AHB size.
  input  wire logic [31:0]              hwdata,           // AHB write data.
  input  wire logic                     hready,           // AHB bus ready.
  output logic                          hreadyout,        // AHB slave ready.
  output logic [31:0]                   hrdata,           // AHB read data.
  output logic                          hresp,            // AHB response, always OKAY.
  input  wire logic                     step,             // Instruction boundary strobe.
  input  program_sequencer_pkg::seq_op_s op,              // Operation of this boundary.
  input  wire logic                     extInt_n,         // External interrupt pin.
  input  wire logic                     timer0Overflow,   // First counter overflow pulse.
  input  wire logic                     timer1Overflow,   // Second counter overflow pulse.
  output logic [12:0]                   pc,               // Program counter.
  output logic [15:0]                   fetchWord,        // Word at the program counter.
  output logic                          discardFetch,     // Fetched word must be dropped.
  output logic                          intTaken,         // Interrupt acknowledged pulse.
  output logic                          lookupBusy,       // Table read in progress.
  input  wire logic                     ispMode,          // Programming mode pin level.
  input  wire logic                     portABitFour,     // Serial programming clock pin.
  input  wire logic                     portABitZeroIn,   // Serial programming data in.
  output logic                          portABitZeroOut,  // Serial programming data out.
  output logic                          portABitZeroOe    // Serial data output enable.
);

  // ****************************************************************
  // Reset release and pin synchronisers.
  // ****************************************************************
  logic       rstMeta;    // First reset release stage.
  logic       rstSync;    // Reset for the design, active low.
  logic [1:0] extSync;    // External interrupt synchroniser.
  logic [1:0] ispSync;    // Programming mode synchroniser.
  logic [1:0] sclkSync;   // Serial clock synchroniser.
  logic [1:0] sdataSync;  // Serial data synchroniser.
  logic       extPrev;    // Last synchronised interrupt level.
  logic       sclkPrev;   // Last synchronised serial clock level.

  // Release reset through two flops.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // Bring the pins into the clock domain through two flops.
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      extSync   <= 2'h3;
      ispSync   <= 2'h0;
      sclkSync  <= 2'h0;
      sdataSync <= 2'h0;
      extPrev   <= 1'b1;
      sclkPrev  <= 1'b0;
    end else if (ce) begin
      extSync   <= {extSync[0], extInt_n};
      ispSync   <= {ispSync[0], ispMode};
      sclkSync  <= {sclkSync[0], portABitFour};
      sdataSync <= {sdataSync[0], portABitZeroIn};
      extPrev   <= extSync[1];
      sclkPrev  <= sclkSync[1];
    end
  end

  // ****************************************************************
  // Storage.
  // ****************************************************************
  logic [15:0] progMem [PROG_WORDS];     // Program memory.
  logic [12:0] stackMem [STACK_LEVELS];  // Return stack.
  logic [7:0]  gpRam [`GP_BYTES];        // General purpose bytes.

  logic [3:0]  stackIndex;   // Next free stack level.
  logic [4:0]  stackDepth;   // Entries held.
  logic [7:0]  lookupPointer;  // Table pointer.
  logic [7:0]  lookupHighByte; // Table high byte.
  logic [7:0]  pointerZero;  // Indirect pointer zero.
  logic [7:0]  pointerOne;   // Indirect pointer one.
  logic [7:0]  bankPointer;  // Bank pointer.
  logic [2:0]  intEnable;    // Per source enables.
  logic [2:0]  intFlag;      // Pending requests.
  logic        lowPending;   // A low byte write awaits the next boundary.
  logic [7:0]  lowValue;     // Value written to the low byte.
  program_sequencer_pkg::lookup_state_e lookupState; // Table read state.
  logic [12:0] lookupAddr;   // Table word address.
  logic [7:0]  lookupDest;   // Destination of the low byte.

  // ****************************************************************
  // Bus slave.
  // ****************************************************************
  logic        busPhase;     // A data phase is open.
  logic        busWrite;     // Open phase is a write.
  logic [7:0]  busIndex;     // Register index of the open phase.
  logic        busWrEn;      // Write strobe in the wait state cycle.
  logic        busAccept;    // Address phase accepted.

  assign busAccept = hsel && hready && htrans[1];
  assign busWrEn   = busPhase && busWrite && ce;

  // Every transfer takes one wait state, then completes with OKAY.
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      busPhase  <= 1'b0;
      busWrite  <= 1'b0;
      busIndex  <= `BYTE_RESET;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      if (busPhase) begin
        busPhase  <= 1'b0;
        hreadyout <= 1'b1;
      end else if (busAccept) begin
        busPhase  <= 1'b1;
        busWrite  <= hwrite;
        busIndex  <= haddr[9:2];
        hreadyout <= 1'b0;
      end
    end
  end

  // Read one data location; indirect reads of any location below 20h give zero.
  function automatic logic [7:0] readByte(input logic [7:0] idx, input logic direct);
    logic [7:0] val;
    val = `BYTE_RESET;
    if (idx >= `IDX_GP_BASE) begin
      val = gpRam[idx - `IDX_GP_BASE];
    end else if (direct) begin
      case (idx)
        `IDX_POINTER0:    val = pointerZero;
        `IDX_POINTER1:    val = pointerOne;
        `IDX_BANK:        val = bankPointer;
        `IDX_PC_LOW:      val = pc[7:0];
        `IDX_LOOKUP_PTR:  val = lookupPointer;
        `IDX_LOOKUP_HIGH: val = lookupHighByte;
        `IDX_INT_CTRL:    val = {1'b0, intFlag, 1'b0, intEnable};
        default:          val = `BYTE_RESET;
      endcase
    end
    return val;
  endfunction : readByte

  // Read data is produced in the wait state; unused locations read zero.
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      hrdata <= 32'h0000_0000;
    end else if (ce && busPhase && !busWrite) begin
      if (busIndex == `IDX_INDIRECT0) begin
        hrdata <= {24'h00_0000, readByte(pointerZero, 1'b0)};
      end else if (busIndex == `IDX_INDIRECT1) begin
        hrdata <= {24'h00_0000, readByte(pointerOne, 1'b0)};
      end else begin
        hrdata <= {24'h00_0000, readByte(busIndex, 1'b1)};
      end
    end
  end

  // Effective write target, following the indirect pointers.
  logic [7:0] wrIndex;   // Location that a bus write reaches.
  always_comb begin
    case (busIndex)
      `IDX_INDIRECT0: wrIndex = pointerZero;
      `IDX_INDIRECT1: wrIndex = pointerOne;
      default:        wrIndex = busIndex;
    endcase
  end

  // Plain software registers.
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      pointerZero   <= `BYTE_RESET;
      pointerOne    <= `BYTE_RESET;
      bankPointer   <= `BYTE_RESET;
      lookupPointer <= `BYTE_RESET;
      intEnable     <= 3'h0;
    end else if (busWrEn) begin
      case (busIndex)
        `IDX_POINTER0:   pointerZero <= hwdata[7:0];
        `IDX_POINTER1:   pointerOne <= hwdata[7:0];
        `IDX_BANK:       bankPointer <= hwdata[7:0];
        `IDX_LOOKUP_PTR: lookupPointer <= hwdata[7:0];
        `IDX_INT_CTRL:   intEnable <= hwdata[`INT_EN_LSB +: 3];
        default:         ;
      endcase
    end
  end

  // ****************************************************************
  // Sequencing decisions.
  // ****************************************************************
  logic        stackFull;   // All levels in use.
  logic        canStep;     // The boundary may be taken.
  logic        intAck;      // An interrupt is acknowledged now.
  logic [12:0] intVector;   // Entry of the winning source.
  logic [2:0]  intClear;    // Flag cleared by the acknowledge.
  logic [12:0] stackTop;    // Most recent return address.

  assign stackFull = (stackDepth == 5'(STACK_LEVELS));
  assign canStep   = ce && step && !ispSync[1] && (lookupState == program_sequencer_pkg::LOOKUP_IDLE);
  assign stackTop  = stackMem[stackIndex - 4'h1];
  assign intAck    = canStep && !stackFull && (|(intFlag & intEnable));

  always_comb begin
    intVector = `VEC_TIMER1;
    intClear  = 3'b100;
    if (intFlag[0] && intEnable[0]) begin
      intVector = `VEC_EXT_INT;
      intClear  = 3'b001;
    end else if (intFlag[1] && intEnable[1]) begin
      intVector = `VEC_TIMER0;
      intClear  = 3'b010;
    end else begin
      intVector = `VEC_TIMER1;
      intClear  = 3'b100;
    end
  end

  // Request flags: a new event wins over a clear in the same cycle.
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      intFlag <= 3'h0;
    end else if (ce) begin
      intFlag <= (intFlag
                  & ~(intAck ? intClear : 3'h0)
                  & ~((busWrEn && busIndex == `IDX_INT_CTRL) ? ~hwdata[`INT_FLAG_LSB +: 3] : 3'h0))
                 | {timer1Overflow, timer0Overflow, extPrev && !extSync[1]};
    end
  end

  // Low byte writes wait for the next boundary to take effect.
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      lowPending <= 1'b0;
      lowValue   <= `BYTE_RESET;
    end else if (ce) begin
      if (busWrEn && busIndex == `IDX_PC_LOW) begin
        lowPending <= 1'b1;
        lowValue   <= hwdata[7:0];
      end else if (canStep && !intAck) begin
        lowPending <= 1'b0;
      end
    end
  end

  // Program counter and pipeline discard.
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      pc           <= `VEC_RESET;
      discardFetch <= 1'b0;
      intTaken     <= 1'b0;
    end else if (ce) begin
      intTaken <= intAck;
      if (canStep) begin
        discardFetch <= 1'b1;
        if (intAck) begin
          pc <= intVector;
        end else if (lowPending) begin
          pc <= {pc[12:8], lowValue};
        end else begin
          case (op.kind)
            program_sequencer_pkg::OP_SKIP: pc <= pc + 13'h0002;
            program_sequencer_pkg::OP_JUMP,
            program_sequencer_pkg::OP_CALL: pc <= op.target;
            program_sequencer_pkg::OP_RETURN_FROM_CALL,
            program_sequencer_pkg::OP_RETURN_FROM_INTERRUPT: pc <= stackTop;
            default: begin
              pc           <= pc + 13'h0001;
              discardFetch <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // ****************************************************************
  // Return stack.
  // ****************************************************************
  logic doPush;   // Push this cycle.
  logic doPop;    // Pop this cycle.
  assign doPush = intAck || (canStep && !lowPending && op.kind == program_sequencer_pkg::OP_CALL);
  assign doPop  = canStep && !intAck && !lowPending && stackDepth != 5'h00 &&
                  (op.kind == program_sequencer_pkg::OP_RETURN_FROM_CALL ||
                   op.kind == program_sequencer_pkg::OP_RETURN_FROM_INTERRUPT);

  always_ff @(posedge clk) begin
    if (ce && doPush) begin
      stackMem[stackIndex] <= intAck ? pc : pc + 13'h0001;
    end
  end

  // Index wraps, so a push on a full stack replaces the oldest level.
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      stackIndex <= 4'h0;
      stackDepth <= 5'h00;
    end else if (ce) begin
      if (doPush) begin
        stackIndex <= stackIndex + 4'h1;
        if (!stackFull) begin
          stackDepth <= stackDepth + 5'h01;
        end
      end else if (doPop) begin
        stackIndex <= stackIndex - 4'h1;
        stackDepth <= stackDepth - 5'h01;
      end
    end
  end

  // ****************************************************************
  // Table read.
  // ****************************************************************
  logic lookupDone;   // Second cycle of a table read.
  assign lookupDone = ce && lookupState == program_sequencer_pkg::LOOKUP_FETCH;

  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      lookupState    <= program_sequencer_pkg::LOOKUP_IDLE;
      lookupAddr     <= `VEC_RESET;
      lookupDest     <= `BYTE_RESET;
      lookupHighByte <= `BYTE_RESET;
      lookupBusy     <= 1'b0;
    end else if (ce) begin
      case (lookupState)
        program_sequencer_pkg::LOOKUP_IDLE: begin
          if (canStep && !intAck && !lowPending) begin
            if (op.kind == program_sequencer_pkg::OP_LOOKUP_READ_CURRENT_PAGE) begin
              lookupAddr  <= {pc[12:8], lookupPointer};
              lookupDest  <= op.dest;
              lookupState <= program_sequencer_pkg::LOOKUP_FETCH;
              lookupBusy  <= 1'b1;
            end else if (op.kind == program_sequencer_pkg::OP_LOOKUP_READ_LAST_PAGE) begin
              lookupAddr  <= {`LAST_PAGE, lookupPointer};
              lookupDest  <= op.dest;
              lookupState <= program_sequencer_pkg::LOOKUP_FETCH;
              lookupBusy  <= 1'b1;
            end
          end
        end
        program_sequencer_pkg::LOOKUP_FETCH: begin
          lookupHighByte <= progMem[lookupAddr][15:8];
          lookupState    <= program_sequencer_pkg::LOOKUP_IDLE;
          lookupBusy     <= 1'b0;
        end
        default: lookupState <= program_sequencer_pkg::LOOKUP_IDLE;
      endcase
    end
  end

  // General purpose bytes: bus writes and the table low byte.
  always_ff @(posedge clk) begin
    if (busWrEn && wrIndex >= `IDX_GP_BASE) begin
      gpRam[wrIndex - `IDX_GP_BASE] <= hwdata[7:0];
    end
    if (lookupDone && lookupDest >= `IDX_GP_BASE) begin
      gpRam[lookupDest - `IDX_GP_BASE] <= progMem[lookupAddr][7:0];
    end
  end

  // ****************************************************************
  // Program memory and serial programming.
  // ****************************************************************
  logic [28:0] ispShift;  // Address then data, most significant first.
  logic [4:0]  ispCount;  // Bits received in this frame.
  logic        ispWrite;  // Frame complete, write the word.

  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      ispShift        <= 29'h0;
      ispCount        <= 5'h00;
      ispWrite        <= 1'b0;
      portABitZeroOut <= 1'b0;
      portABitZeroOe  <= 1'b0;
    end else if (ce) begin
      ispWrite <= 1'b0;
      if (!ispSync[1]) begin
        ispCount <= 5'h00;
      end else if (sclkSync[1] && !sclkPrev) begin
        ispShift <= {ispShift[27:0], sdataSync[1]};
        if (ispCount == 5'(`ISP_FRAME_BITS - 1)) begin
          ispCount <= 5'h00;
          ispWrite <= 1'b1;
        end else begin
          ispCount <= ispCount + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (ce && ispWrite) begin
      progMem[ispShift[28:16]] <= ispShift[15:0];
    end
  end

  // Word at the program counter, one cycle behind it.
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      fetchWord <= 16'h0000;
    end else if (ce) begin
      fetchWord <= progMem[pc];
    end
  end

endmodule : program_sequencer

// ---- src/program_sequencer_defines.svh ----
`ifndef PROGRAM_SEQUENCER_DEFINES_SVH
`define PROGRAM_SEQUENCER_DEFINES_SVH

// ****************************************************************
// Program counter width and the fixed entry addresses.
// ****************************************************************
`define PC_WIDTH        13
`define VEC_RESET       13'h0000
`define VEC_EXT_INT     13'h0004
`define VEC_TIMER0      13'h0008
`define VEC_TIMER1      13'h000c
`define LAST_PAGE       5'h1f

// ****************************************************************
// Data space register indices (byte address is four times these).
// ****************************************************************
`define IDX_INDIRECT0   8'h00
`define IDX_POINTER0    8'h01
`define IDX_INDIRECT1   8'h02
`define IDX_POINTER1    8'h03
`define IDX_BANK        8'h04
`define IDX_PC_LOW      8'h06
`define IDX_LOOKUP_PTR  8'h07
`define IDX_LOOKUP_HIGH 8'h08
`define IDX_INT_CTRL    8'h0b
`define IDX_GP_BASE     8'h20

// ****************************************************************
// Field positions of the interrupt control register.
// ****************************************************************
`define INT_EN_LSB      0
`define INT_FLAG_LSB    4

// ****************************************************************
// Sizes and reset values.
// ****************************************************************
`define STACK_LEVELS    16
`define PROG_WORDS      8192
`define GP_BYTES        224
`define ISP_FRAME_BITS  29
`define BYTE_RESET      8'h00

`endif

// ---- src/program_sequencer_pkg.sv ----
package program_sequencer_pkg;

  // Operation that the decoder presents at each instruction boundary.
  typedef enum logic [2:0] {
    OP_NEXT,
    OP_SKIP,
    OP_JUMP,
    OP_CALL,
    OP_RETURN_FROM_CALL,
    OP_RETURN_FROM_INTERRUPT,
    OP_LOOKUP_READ_CURRENT_PAGE,
    OP_LOOKUP_READ_LAST_PAGE
  } seq_op_kind_e;

  // Operation with its operands.
  typedef struct packed {
    seq_op_kind_e kind;   // What the instruction does to the flow.
    logic [12:0]  target; // Address field of jump and call.
    logic [7:0]   dest;   // Data location for the table low byte.
  } seq_op_s;

  // Table read progress.
  typedef enum logic {
    LOOKUP_IDLE,
    LOOKUP_FETCH
  } lookup_state_e;

endpackage : program_sequencer_pkg
